// *** src/tamrc_cfg.svh ***
`ifndef TAMRC_CFG_SVH
`define TAMRC_CFG_SVH
// ==========================================================================
// Host port map (word offsets from base)
`define TAMRC_OFS_DATA      2'h0
`define TAMRC_OFS_COMM      2'h1
`define TAMRC_OFS_MOVE      2'h2
// Comm status bit positions
`define TAMRC_CS_CMD_READY  0
`define TAMRC_CS_RB_AVAIL   1
`define TAMRC_CS_ERROR      2
`define TAMRC_CS_BOOTED     3
`define TAMRC_CS_CMD_OVF    4
`define TAMRC_CS_RB_UNDF    5
// Timing
`define TAMRC_CLK_HZ        25000000
`define TAMRC_ADC_DWELL_NS  50000
`define TAMRC_ADC_DWELL_CYC ((`TAMRC_ADC_DWELL_NS * (`TAMRC_CLK_HZ / 1000000)) / 1000)
`define TAMRC_LOOP_CYC      16'h09C4
// Reset values
`define TAMRC_RST_AXISCFG   8'h00
`endif

// *** src/tamrc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tamrc_cfg.svh"
module tamrc_core #(
   parameter int AXES   = 2,                 // Axis count
   parameter int POS_W  = 16,                // Position width
   parameter int FLASH_WORDS = 4             // Boot image words
) (
   input  wire logic              core_clk,     // Clock
   input  wire logic              reset_n,      // Sync reset, active low
   // Host port
   input  wire logic              hostSel,      // Access strobe
   input  wire logic              hostWrite,    // 1 write, 0 read
   input  wire logic [1:0]        hostAddr,     // Word offset
   input  wire logic [15:0]       hostWdata,    // Write data
   output logic      [15:0]       hostRdata,    // Read data
   output logic                   hostAck,      // Access done pulse
   // Processor side of buffers
   output logic      [15:0]       cmdWord,      // Command to processor
   output logic                   cmdValid,     // Command word pulse
   input  wire logic [15:0]       rbWord,       // Readback from processor
   input  wire logic              rbLoad,       // Readback push
   input  wire logic              errorFlag,    // Real-time error
   // Flash boot
   output logic      [7:0]        flashAddr,    // Flash word address
   input  wire logic [15:0]       flashData,    // Flash data
   input  wire logic              flashSaved,   // Saved parameter set valid
   output logic                   booted,       // Boot finished
   // Axis configuration and motion
   input  wire tamrc_pkg::tamrc_axis_cfg_type [1:0] axisCfg, // Axis maps
   input  wire logic [POS_W-1:0]  axisStep,     // Shared velocity
   input  wire logic [1:0]        moveDoneIn,   // Loop move done
   output logic      [POS_W-1:0]  servoCmd [2], // To servo loops
   output logic      [POS_W-1:0]  stepCmd [2],  // To step generators
   output logic      [1:0]        cfgFault,     // Invalid map per axis
   output logic      [1:0]        axisClassStep,// Axis is stepper
   // ADC
   input  wire logic [1:0]        adcEnable,    // Channel enables
   input  wire logic [11:0]       adcData,      // Converter result
   output logic                   adcChan,      // Mux select
   output tamrc_pkg::tamrc_packet_type adcPacket, // To both processors
   output logic                   adcPktValid,  // Packet pulse
   // Motion I/O pins
   input  wire logic [1:0]        fwdLimit,     // Forward limits
   input  wire logic [1:0]        revLimit,     // Reverse limits
   input  wire logic [1:0]        homeIn,       // Home inputs
   input  wire logic [1:0]        trigIn,       // Capture triggers
   input  wire logic [1:0]        bkptDrive,    // Breakpoint requests
   input  wire logic [1:0]        inhDrive,     // Inhibit requests
   output logic      [1:0]        bkptOut,      // Breakpoint outputs
   output logic      [1:0]        inhOut,       // Inhibit outputs
   output logic      [7:0]        motionIoIn    // Inputs by axis
);
   // ==========================================================================
   // Elaboration checks: refuse sizes the logic cannot serve
   initial begin
      if (AXES != 2) $error("core serves two axes only");
      if (POS_W < 15) $error("position too narrow for direct writes");
      if (FLASH_WORDS < 1 || FLASH_WORDS > 256) $error("boot image size out of range");
   end
   localparam int DWELL = (`TAMRC_ADC_DWELL_CYC < 1) ? 1 : `TAMRC_ADC_DWELL_CYC;

   // ==========================================================================
   // Classification function
   function automatic tamrc_pkg::tamrc_axis_class_type classOf(
      input tamrc_pkg::tamrc_axis_cfg_type c);
      if (!c.mapped) classOf = tamrc_pkg::TAMRC_UNUSED;
      else if (c.outIsStepper) classOf = tamrc_pkg::TAMRC_STEPPER;
      else classOf = tamrc_pkg::TAMRC_SERVO;
   endfunction

   // ==========================================================================
   // Boot sequence
   typedef enum logic [1:0] {BOOT_IMAGE, BOOT_PARAMS, BOOT_RUN} tamrc_boot_type;
   tamrc_boot_type bootState;                   // Boot phase
   logic [15:0]    paramShadow;                 // Restored parameter word
   // Walk the image words, then pick up saved parameters
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         bootState   <= BOOT_IMAGE;
         flashAddr   <= 8'h00;
         booted      <= 1'b0;
         paramShadow <= 16'h0000;
      end else begin
         case (bootState)
            BOOT_IMAGE: begin
               flashAddr <= flashAddr + 8'h01;
               if (flashAddr == 8'(FLASH_WORDS - 1)) bootState <= BOOT_PARAMS;
            end
            BOOT_PARAMS: begin
               if (flashSaved) paramShadow <= flashData;
               bootState <= BOOT_RUN;
               booted    <= 1'b1;
            end
            BOOT_RUN: bootState <= BOOT_RUN;
            default: bootState <= BOOT_IMAGE;
         endcase
      end
   end

   // ==========================================================================
   // Loop tick
   logic [15:0] loopCnt;                        // Loop period counter
   logic        tick;                           // Loop update pulse
   // Free-running period counter, held while booting
   always_ff @(posedge core_clk) begin
      if (!reset_n || !booted) begin
         loopCnt <= 16'h0000;
         tick    <= 1'b0;
      end else begin
         tick    <= (loopCnt == `TAMRC_LOOP_CYC - 16'h0001);
         loopCnt <= (loopCnt == `TAMRC_LOOP_CYC - 16'h0001) ? 16'h0000 : loopCnt + 16'h0001;
      end
   end

   // ==========================================================================
   // Generators: two per axis, routed by axis class
   logic [POS_W-1:0] genPos [4];                // Generator positions
   logic [3:0]       genValid;                  // Generator pulses
   genvar g;
   // Odd generators join only for blended or unbounded moves
   generate
      for (g = 0; g < 4; g++) begin : gen_traj
         logic run;
         assign run = axisCfg[g/2].mapped &&
                      ((g % 2 == 0) || axisCfg[g/2].moveMode != 2'h0);
         tamrc_traj_gen #(.POS_W(POS_W)) u_gen (
            .core_clk (core_clk),
            .reset_n  (reset_n),
            .tick     (tick),
            .enable   (run),
            .step     (axisStep),
            .position (genPos[g]),
            .valid    (genValid[g])
         );
      end
      for (g = 0; g < 2; g++) begin : gen_axis
         // Route the summed command by axis class
         always_ff @(posedge core_clk) begin
            if (!reset_n) begin
               servoCmd[g]      <= '0;
               stepCmd[g]       <= '0;
               cfgFault[g]      <= 1'b0;
               axisClassStep[g] <= 1'b0;
            end else begin
               axisClassStep[g] <= classOf(axisCfg[g]) == tamrc_pkg::TAMRC_STEPPER;
               // Feedback and secondary encoder checks
               cfgFault[g] <= axisCfg[g].mapped &&
                  ((axisCfg[g].secondEnc && axisCfg[g].outIsStepper) ||
                   (axisCfg[g].secondEnc && axisCfg[1-g].secondEnc) ||
                   (axisCfg[g].outIsStepper && axisCfg[g].closedLoop &&
                    !axisCfg[g].fbIsAdc && axisCfg[1-g].secondEnc));
               if (genValid[2*g]) begin
                  if (classOf(axisCfg[g]) == tamrc_pkg::TAMRC_SERVO)
                     servoCmd[g] <= genPos[2*g] + genPos[2*g+1];
                  else
                     stepCmd[g] <= genPos[2*g] + genPos[2*g+1];
               end else if (!axisCfg[g].mapped && hostSel && hostWrite &&
                            hostAddr == `TAMRC_OFS_DATA && hostWdata[15]) begin
                  servoCmd[g] <= POS_W'(hostWdata[14:0]);
               end
            end
         end
      end
   endgenerate

   // ==========================================================================
   // ADC scanning over enabled channels
   logic [15:0] dwellCnt;                       // Dwell counter
   // Dwell on each enabled channel, skip the rest
   // A packet is raised only for an enabled channel
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         dwellCnt    <= 16'h0000;
         adcChan     <= 1'b0;
         adcPktValid <= 1'b0;
         adcPacket   <= '0;
      end else begin
         adcPktValid <= 1'b0;
         if (adcEnable == 2'h0) begin
            dwellCnt <= 16'h0000;
         end else if (dwellCnt == 16'(DWELL - 1)) begin
            dwellCnt    <= 16'h0000;
            if (adcEnable[adcChan]) begin
               adcPacket   <= '{kind: 2'h1, payload: {1'b0, adcChan, adcData}};
               adcPktValid <= 1'b1;
            end
            if (adcEnable[~adcChan]) adcChan <= ~adcChan;
         end else begin
            dwellCnt <= dwellCnt + 16'h0001;
            if (!adcEnable[adcChan]) adcChan <= ~adcChan;
         end
      end
   end

   // ==========================================================================
   // Motion I/O: synchronised inputs, axis-addressed
   logic [7:0] ioMeta;                          // First sync stage
   // Two flops on every limit, home and trigger pin before anything reads it; breakpoint and inhibit requests get one
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ioMeta     <= 8'h00;
         motionIoIn <= 8'h00;
         bkptOut    <= 2'h0;
         inhOut     <= 2'h0;
      end else begin
         ioMeta     <= {trigIn, homeIn, revLimit, fwdLimit};
         motionIoIn <= ioMeta;
         bkptOut    <= bkptDrive;
         inhOut     <= inhDrive;
      end
   end

   // ==========================================================================
   // Host buffers: single-word command and readback holding
   logic        rbFull;                         // Readback word held
   logic [15:0] rbHold;                         // Readback buffer
   logic        cmdOvf;                         // Sticky overflow
   logic        rbUndf;                         // Sticky underflow
   logic [1:0]  moveSync;                       // Move state stage
   // Registered answers; overflow and underflow flags stay set until reset
   // A readback load in the same cycle as a read keeps the word
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cmdWord   <= 16'h0000;
         cmdValid  <= 1'b0;
         rbFull    <= 1'b0;
         rbHold    <= 16'h0000;
         cmdOvf    <= 1'b0;
         rbUndf    <= 1'b0;
         hostAck   <= 1'b0;
         hostRdata <= 16'h0000;
         moveSync  <= 2'h0;
      end else begin
         cmdValid <= 1'b0;
         hostAck  <= hostSel;
         moveSync <= moveDoneIn;
         if (rbLoad) begin
            rbHold <= rbWord;
            rbFull <= 1'b1;
         end
         if (hostSel && hostWrite && hostAddr == `TAMRC_OFS_DATA) begin
            if (booted) begin
               cmdWord  <= hostWdata;
               cmdValid <= 1'b1;
            end else begin
               cmdOvf <= 1'b1;
            end
         end
         if (hostSel && !hostWrite) begin
            case (hostAddr)
               `TAMRC_OFS_DATA: begin
                  hostRdata <= rbHold;
                  if (!rbFull) rbUndf <= 1'b1;
                  else if (!rbLoad) rbFull <= 1'b0;            // Load wins
               end
               `TAMRC_OFS_COMM: begin
                  hostRdata <= 16'h0000;
                  hostRdata[`TAMRC_CS_CMD_READY] <= booted;
                  hostRdata[`TAMRC_CS_RB_AVAIL]  <= rbFull;
                  hostRdata[`TAMRC_CS_ERROR]     <= errorFlag;
                  hostRdata[`TAMRC_CS_BOOTED]    <= booted;
                  hostRdata[`TAMRC_CS_CMD_OVF]   <= cmdOvf;
                  hostRdata[`TAMRC_CS_RB_UNDF]   <= rbUndf;
               end
               `TAMRC_OFS_MOVE: hostRdata <= {14'h0000, moveSync};
               default: hostRdata <= 16'h0000;
            endcase
         end
         // Writes to status offsets fall through untouched
      end
   end

   // ==========================================================================
   // Checks
   a_ack_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
      hostSel |=> hostAck) else $error("host access not acknowledged");
   a_cmd_forward: assert property (@(posedge core_clk) disable iff (!reset_n)
      (hostSel && hostWrite && hostAddr == 2'h0 && booted) |=> cmdValid && cmdWord == $past(hostWdata))
      else $error("command word lost");
   a_status_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      (hostSel && hostWrite && hostAddr != 2'h0) |=> !cmdValid)
      else $error("status write had effect");
   a_rb_avail: assert property (@(posedge core_clk) disable iff (!reset_n)
      rbLoad |=> rbFull) else $error("readback not held");
   a_adc_enabled: assert property (@(posedge core_clk) disable iff (!reset_n)
      adcPktValid |-> adcEnable[adcPacket.payload[12]]) else $error("disabled channel sent");
   a_gen_tick: assert property (@(posedge core_clk) disable iff (!reset_n)
      genValid[0] |-> $past(tick)) else $error("generator off tick");
   a_second_gen: assert property (@(posedge core_clk) disable iff (!reset_n)
      (tick && axisCfg[0].mapped && axisCfg[0].moveMode == 2'h0) |=> !genValid[1])
      else $error("second generator ran on point move");
   a_boot_first: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmdValid |-> booted) else $error("command before boot");
   // Sticky error flags never drop on their own
   a_ovf_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmdOvf |=> cmdOvf) else $error("overflow flag dropped");
   a_undf_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
      rbUndf |=> rbUndf) else $error("underflow flag dropped");
   // Breakpoint outputs follow their requests one cycle later
   a_bkpt_copy: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) |-> bkptOut == $past(bkptDrive)) else $error("breakpoint lag");
   // Unmapped axis DAC takes direct host values
   a_free_dac: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!axisCfg[1].mapped && !genValid[2] && hostSel && hostWrite && hostAddr == 2'h0 &&
       hostWdata[15]) |=> servoCmd[1][14:0] == $past(hostWdata[14:0]))
      else $error("direct output lost");
endmodule // tamrc_core
`default_nettype wire

// *** src/tamrc_pkg.sv ***
// ==========================================================================
// Shared types
package tamrc_pkg;
   // Per-axis resource map
   typedef struct packed {
      logic       outIsStepper;  // Primary output resource is a stepper
      logic       closedLoop;    // Stepper axis uses feedback
      logic       fbIsAdc;       // Primary feedback is ADC
      logic       secondEnc;     // Secondary encoder requested
      logic       secondOut;     // Secondary output requested
      logic       mapped;        // Axis is in use
      logic [1:0] moveMode;      // 0 point, 1 blended, 2 unbounded
   } tamrc_axis_cfg_type;
   // Axis class
   typedef enum logic [1:0] {TAMRC_UNUSED, TAMRC_SERVO, TAMRC_STEPPER} tamrc_axis_class_type;
   // Internal processor packet
   typedef struct packed {
      logic [1:0]  kind;         // 0 command, 1 data, 2 event
      logic [13:0] payload;      // Packet body
   } tamrc_packet_type;
endpackage : tamrc_pkg

// *** src/tamrc_traj_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tamrc_cfg.svh"
// ==========================================================================
// One trajectory generator: new position command per loop tick
module tamrc_traj_gen #(
   parameter int POS_W = 16                  // Position width
) (
   input  wire logic             core_clk,   // Clock
   input  wire logic             reset_n,    // Sync reset, active low
   input  wire logic             tick,       // Loop update pulse
   input  wire logic             enable,     // Generator running
   input  wire logic [POS_W-1:0] step,       // Velocity per tick
   output logic      [POS_W-1:0] position,   // Instantaneous command
   output logic                  valid       // New command pulse
);
   // ==========================================================================
   // Position integrator
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         position <= '0;
         valid    <= 1'b0;
      end else begin
         valid <= tick & enable;
         if (tick && enable) begin
            position <= position + step;
         end
      end
   end
endmodule // tamrc_traj_gen
`default_nettype wire

// *** test/tamrc_core_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tamrc_cfg.svh"
// ==========================================================================
// Self-checking bench for the motion resource core
module tamrc_core_bench;
   localparam int FW = 4;                                    // Short boot image
   logic core_clk, reset_n, hostSel, hostWrite, hostAck;      // Clock, reset, strobes
   logic cmdValid, rbLoad, errorFlag, flashSaved, booted;     // Single flags
   logic adcChan, adcPktValid;                                // Converter flags
   logic [1:0] hostAddr, moveDoneIn, cfgFault, axisClassStep; // Pairs
   logic [1:0] adcEnable, fwdLimit, revLimit, homeIn, trigIn; // Pins
   logic [1:0] bkptDrive, inhDrive, bkptOut, inhOut;          // Outputs pins
   logic [15:0] hostWdata, hostRdata, cmdWord, rbWord;        // Data words
   logic [15:0] flashData, axisStep, lastCmd;                 // Words
   logic [15:0] servoCmd [2], stepCmd [2];                    // Axis commands
   logic [7:0] flashAddr, motionIoIn;                         // Bytes
   logic [11:0] adcData;                                      // Converter value
   tamrc_pkg::tamrc_axis_cfg_type [1:0] axisCfg;              // Axis maps
   tamrc_pkg::tamrc_packet_type adcPacket;                    // Converter packet
   int errTotal = 0;                                          // Mismatches
   int checkCount = 0;                                        // Comparisons
   int cmdSeen = 0;                                           // Command pulses
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   tamrc_core #(.FLASH_WORDS(FW)) dut (.core_clk(core_clk), .reset_n(reset_n),
      .hostSel(hostSel), .hostWrite(hostWrite), .hostAddr(hostAddr), .hostWdata(hostWdata),
      .hostRdata(hostRdata), .hostAck(hostAck), .cmdWord(cmdWord), .cmdValid(cmdValid),
      .rbWord(rbWord), .rbLoad(rbLoad), .errorFlag(errorFlag), .flashAddr(flashAddr),
      .flashData(flashData), .flashSaved(flashSaved), .booted(booted), .axisCfg(axisCfg),
      .axisStep(axisStep), .moveDoneIn(moveDoneIn), .servoCmd(servoCmd), .stepCmd(stepCmd),
      .cfgFault(cfgFault), .axisClassStep(axisClassStep), .adcEnable(adcEnable),
      .adcData(adcData), .adcChan(adcChan), .adcPacket(adcPacket),
      .adcPktValid(adcPktValid), .fwdLimit(fwdLimit), .revLimit(revLimit), .homeIn(homeIn),
      .trigIn(trigIn), .bkptDrive(bkptDrive), .inhDrive(inhDrive), .bkptOut(bkptOut),
      .inhOut(inhOut), .motionIoIn(motionIoIn));
   tamrc_host_model host (.core_clk(core_clk), .hostSel(hostSel), .hostWrite(hostWrite),
      .hostAddr(hostAddr), .hostWdata(hostWdata), .hostRdata(hostRdata), .hostAck(hostAck));
   // Record every command word handed to the processor
   always @(posedge core_clk) begin
      if (cmdValid === 1'b1) begin
         lastCmd <= cmdWord;
         cmdSeen <= cmdSeen + 1;
      end
   end
   // Word compare
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      checkCount++;
      if (got !== exp) begin
         errTotal++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Flag compare
   task automatic check_bit(input logic got, input logic exp);
      check_val({15'h0000, got}, {15'h0000, exp});
   endtask
   // Verdict and end of run
   task automatic stopTest();
      errTotal += host.hangs;
      $display("Comparisons %0d, mismatches %0d", checkCount, errTotal);
      if (errTotal == 0 && checkCount > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // A bound ran out
   task automatic timeout();
      errTotal++;
      stopTest();
   endtask
   // Wait for an axis command to move; count cycles taken
   task automatic wait_move(input int ax, input logic stp, output logic [15:0] v,
                            output int cyc);
      logic [15:0] old;
      old = stp ? stepCmd[ax] : servoCmd[ax];
      v = old;
      for (cyc = 0; cyc < 3000 && v === old; cyc++) begin
         @(negedge core_clk);
         v = stp ? stepCmd[ax] : servoCmd[ax];
      end
      if (v === old) timeout();
   endtask
   // Catch one converter packet
   task automatic wait_pkt(output logic [15:0] q);
      int n;
      for (n = 0; n < 3000 && adcPktValid !== 1'b1; n++) @(negedge core_clk);
      if (adcPktValid !== 1'b1) timeout();
      q = adcPacket;
      @(negedge core_clk);
   endtask
   // ==========================================================================
   // Main sequence
   initial begin
      logic [15:0] q, d, v1, v2;
      int n, s, c;
      reset_n = 1'b0;
      {rbLoad, errorFlag, flashSaved, moveDoneIn, adcEnable} = 7'h04;
      {fwdLimit, revLimit, homeIn, trigIn, bkptDrive, inhDrive} = 12'h000;
      {rbWord, flashData, axisStep, adcData} = 60'h0;
      axisCfg = 16'h0000;
      n = $urandom(61);
      flashData = 16'($urandom());
      repeat (20) @(negedge core_clk);
      reset_n = 1'b1;
      check_bit(booted, 1'b0);
      // Command sent before boot ends is dropped
      host.access(1'b1, `TAMRC_OFS_DATA, 16'h0BAD, q);
      for (n = 0; n < FW + 4 && booted !== 1'b1; n++) @(negedge core_clk);
      check_bit(booted, 1'b1);
      host.access(1'b0, `TAMRC_OFS_COMM, 16'h0000, q);
      check_val(q & 16'h0018, 16'h0018);
      check_val(16'(cmdSeen), 16'h0000);
      // Command stream with corner words
      for (n = 0; n < 6; n++) begin
         d = (n == 0) ? 16'h0000 : (n == 1) ? 16'h7FFF : 16'($urandom() & 32'h7FFF);
         host.send_cmd(d);
         @(negedge core_clk);
         check_val(lastCmd, d);
         check_val(16'(cmdSeen), 16'(n + 1));
      end
      // Readback words, then a read with nothing waiting
      for (n = 0; n < 3; n++) begin
         d = 16'($urandom());
         rbWord = d;
         rbLoad = 1'b1;
         @(negedge core_clk);
         rbLoad = 1'b0;
         rbWord = ~d;
         host.fetch_rb(q);
         check_val(q, d);
      end
      host.access(1'b0, `TAMRC_OFS_DATA, 16'h0000, q);
      host.access(1'b0, `TAMRC_OFS_COMM, 16'h0000, q);
      check_val(q & 16'h0022, 16'h0020);
      // Error level mirrored in comm status
      for (n = 0; n < 2; n++) begin
         errorFlag = n[0];
         host.access(1'b0, `TAMRC_OFS_COMM, 16'h0000, q);
         check_bit(q[`TAMRC_CS_ERROR], n[0]);
      end
      // Live move status
      for (n = 0; n < 4; n++) begin
         moveDoneIn = n[1:0];
         host.access(1'b0, `TAMRC_OFS_MOVE, 16'h0000, q);
         check_val(q & 16'h0003, 16'(n));
      end
      // Writes to status registers change nothing
      host.access(1'b0, `TAMRC_OFS_COMM, 16'h0000, v1);
      s = cmdSeen;
      host.access(1'b1, `TAMRC_OFS_COMM, 16'($urandom()), q);
      host.access(1'b1, `TAMRC_OFS_MOVE, 16'hFFFF, q);
      host.access(1'b0, `TAMRC_OFS_COMM, 16'h0000, v2);
      check_val(v2, v1);
      host.access(1'b0, `TAMRC_OFS_MOVE, 16'h0000, q);
      check_val(q & 16'h0003, 16'h0003);
      check_val(16'(cmdSeen), 16'(s));
      // Motion pins
      for (n = 0; n < 4; n++) begin
         {trigIn, homeIn, revLimit, fwdLimit} = 8'($urandom());
         {bkptDrive, inhDrive} = 4'($urandom());
         repeat (3) @(negedge core_clk);
         check_val({8'h00, motionIoIn}, {8'h00, trigIn, homeIn, revLimit, fwdLimit});
         check_val({12'h000, bkptOut, inhOut}, {12'h000, bkptDrive, inhDrive});
      end
      // Second encoder allowed on servo, refused on stepper
      axisCfg = 16'h0414;
      repeat (3) @(negedge core_clk);
      check_val({14'h0000, cfgFault}, 16'h0000);
      axisCfg = 16'h9404;
      repeat (3) @(negedge core_clk);
      check_val({14'h0000, cfgFault}, 16'h0002);
      check_val({14'h0000, axisClassStep}, 16'h0002);
      // Generators per move mode: servo axis 0, stepper axis 1
      axisStep = 16'($urandom_range(200, 1));
      for (n = 0; n < 3; n++) begin
         axisCfg = {8'h84, 8'h04 | 8'(n)};
         v1 = stepCmd[0];
         wait_move(0, 1'b0, q, c);
         wait_move(0, 1'b0, q, c);
         wait_move(0, 1'b0, d, c);
         check_val(d - q, (n == 0) ? axisStep : 16'(axisStep * 2));
         check_val(16'(c), `TAMRC_LOOP_CYC);
         check_val(stepCmd[0], v1);
      end
      wait_move(1, 1'b1, q, c);
      wait_move(1, 1'b1, d, c);
      check_val(d - q, axisStep);
      check_val({14'h0000, cfgFault}, 16'h0000);
      // Converter scan: one channel, then both
      adcData = 12'($urandom());
      adcEnable = 2'b10;
      for (n = 0; n < 2; n++) begin
         wait_pkt(q);
         check_val(q, {4'h5, adcData});
      end
      adcEnable = 2'b11;
      wait_pkt(q);
      wait_pkt(d);
      check_val(q ^ d, 16'h1000);
      // Unmapped axis 1 takes a direct output value
      axisCfg = 16'h0084;
      host.send_cmd(16'h8123);
      @(negedge core_clk);
      check_val(servoCmd[1], 16'h0123);
      stopTest();
   end
endmodule // tamrc_core_bench
`default_nettype wire

// *** test/tamrc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tamrc_cfg.svh"
// ==========================================================================
// Host computer on the data port, one access per access call; paced tasks poll status first
module tamrc_host_model (
   input  wire logic        core_clk,   // Clock
   output logic             hostSel,    // Access strobe
   output logic             hostWrite,  // 1 write, 0 read
   output logic [1:0]       hostAddr,   // Word offset
   output logic [15:0]      hostWdata,  // Write data
   input  wire logic [15:0] hostRdata,  // Read data
   input  wire logic        hostAck     // Access done
);
   int hangs = 0;                       // Accesses or status polls that never finished
   // Bus idle at start
   initial begin
      hostSel = 1'b0;
      hostWrite = 1'b0;
      hostAddr = 2'h3;
      hostWdata = 16'hA5A5;
   end
   // One strobe cycle, then wait a bounded time for the answer
   task automatic access(input logic wr, input logic [1:0] a, input logic [15:0] d,
                         output logic [15:0] q);
      int n;
      @(negedge core_clk);
      hostSel = 1'b1;
      hostWrite = wr;
      hostAddr = a;
      hostWdata = d;
      @(negedge core_clk);
      hostSel = 1'b0;
      // Released bus shows no stale value
      hostAddr = ~a;
      hostWdata = ~d;
      for (n = 0; n < 4 && hostAck !== 1'b1; n++) @(negedge core_clk);
      if (hostAck !== 1'b1) hangs++;
      q = hostRdata;
   endtask
   // Poll comm status until a handshake bit shows ready
   task automatic wait_bit(input int b);
      logic [15:0] q;
      int n;
      q = 16'h0000;
      for (n = 0; n < 50 && q[b] !== 1'b1; n++) access(1'b0, `TAMRC_OFS_COMM, 16'h0000, q);
      if (q[b] !== 1'b1) hangs++;
   endtask
   // Paced command write
   task automatic send_cmd(input logic [15:0] d);
      logic [15:0] q;
      wait_bit(`TAMRC_CS_CMD_READY);
      access(1'b1, `TAMRC_OFS_DATA, d, q);
   endtask
   // Paced readback read
   task automatic fetch_rb(output logic [15:0] d);
      wait_bit(`TAMRC_CS_RB_AVAIL);
      access(1'b0, `TAMRC_OFS_DATA, 16'h0000, d);
   endtask
endmodule // tamrc_host_model
`default_nettype wire
